// >>> imis_pkg.sv
// imis_pkg: constants and types for the masked interrupt status block
// assumes a 32-bit register port and fifo levels supplied by the controller
// Overview of operation
// - bit 0 high when tx fifo empty
// - bit 1 when tx count <= tx threshold
// - bit 2 while tx fifo full
// - bit 3 sticky on write to full tx
// - bit 4 high when rx fifo empty
// - bit 5 when rx count >= rx threshold
// - bit 6 while rx fifo full
// - bit 15 sticky when length bytes received
// - bit 16 while slave read request pending
// - bit 17 tx empty during slave read
// - bit 18 while slave write request pending
// - bit 19 sticky master done until acknowledged
// - bit 20 sticky slave done until acknowledged
// - bit 23 sticky slave arbitration lost
// - bit 24 sticky master arbitration lost
// - bit 25 sticky bus error
// - bit 28 sticky master done without stop
// - hold clock low until nostop cleared
package imis_pkg;
	// register offsets
	localparam logic [7:0] IMIS_OFS_RAW    = 8'h30;
	localparam logic [7:0] IMIS_OFS_MASKED = 8'h34;
	localparam logic [7:0] IMIS_OFS_CLEAR  = 8'h38;
	localparam logic [7:0] IMIS_OFS_MASK   = 8'h3C;
	localparam logic [7:0] IMIS_OFS_TXTHR  = 8'h40;
	localparam logic [7:0] IMIS_OFS_RXTHR  = 8'h44;
	// field positions
	localparam int IMIS_B_TXE   = 0;
	localparam int IMIS_B_TXLOW = 1;
	localparam int IMIS_B_TXF   = 2;
	localparam int IMIS_B_TXOVR = 3;
	localparam int IMIS_B_RXE   = 4;
	localparam int IMIS_B_RXHI  = 5;
	localparam int IMIS_B_RXF   = 6;
	localparam int IMIS_B_LEN   = 15;
	localparam int IMIS_B_SRDRQ = 16;
	localparam int IMIS_B_SRDUF = 17;
	localparam int IMIS_B_SWRRQ = 18;
	localparam int IMIS_B_MDONE = 19;
	localparam int IMIS_B_SDONE = 20;
	localparam int IMIS_B_SARB  = 23;
	localparam int IMIS_B_MARB  = 24;
	localparam int IMIS_B_BERR  = 25;
	localparam int IMIS_B_NOSTP = 28;
	// implemented bits; reserved and excluded bits read zero
	localparam logic [31:0] IMIS_IMPL_MASK = 32'h139F_807F;
	// sticky (event) bits, cleared by the clear register
	localparam logic [31:0] IMIS_STICKY    = 32'h139A_8008;
	// reset values
	localparam logic [31:0] IMIS_RST_WORD  = 32'h0000_0000;
	localparam logic [7:0]  IMIS_RST_THR   = 8'h00;
	// one-cycle pulse events from the controller
	typedef struct packed {
		logic tx_write_full;  // write attempt into full tx fifo
		logic len_reached;    // programmed length received
		logic mst_done;       // master transaction done
		logic slv_done;       // slave transaction done
		logic slv_arb_lost;   // slave lost arbitration
		logic mst_arb_lost;   // master lost arbitration
		logic bus_err;        // unexpected start or stop
		logic mst_done_nostop;// master done, no stop issued
	} imis_evt_t;
	// level conditions from the controller
	typedef struct packed {
		logic slv_rd_req;     // remote read from us pending
		logic slv_rd_active;  // slave read in progress
		logic slv_wr_req;     // remote write to us pending
	} imis_lvl_t;
endpackage

// >>> imis_top.sv
// imis_top: raw and masked interrupt status with mask, clear and thresholds
// assumes single 50 MHz clock, synchronous inputs, fifo counts from fifos
`timescale 1ns/100ps
`default_nettype none
module imis_top #(
	parameter int FIFO_DEPTH = 16,   // entries per fifo
	parameter int CNT_W      = 5     // width of fifo level counts
)(
	input  wire logic               CLK_I,       // 50 MHz clock
	input  wire logic               NRST_I,      // async reset, active low
	input  wire logic               CE_I,        // clock enable, freezes state
	input  wire logic [7:0]         ADDR_I,      // register byte address
	input  wire logic [31:0]        WDATA_I,     // write data
	input  wire logic               WR_I,        // write strobe
	input  wire logic               RD_I,        // read strobe
	output logic      [31:0]        RDATA_O,     // read data, cycle after strobe
	input  wire logic [CNT_W-1:0]   TX_CNT_I,    // tx fifo entries
	input  wire logic [CNT_W-1:0]   RX_CNT_I,    // rx fifo entries
	input  wire imis_pkg::imis_evt_t EVT_I,      // event pulses
	input  wire imis_pkg::imis_lvl_t LVL_I,      // level conditions
	output logic      [31:0]        MASKED_O,    // masked status word
	output logic                    SCL_HOLD_O   // hold serial clock low
);
	// state
	logic [31:0] sticky_r;   // latched event bits
	logic [31:0] mask_r;     // interrupt enable mask
	logic [7:0]  txthr_r;    // tx threshold
	logic [7:0]  rxthr_r;    // rx threshold
	logic [31:0] raw;        // full raw status
	logic [31:0] lvl;        // level-derived status
	logic [31:0] set_ev;     // event set vector
	logic [31:0] clr;        // clear vector from software
	logic        tx_empty;   // tx fifo empty
	logic        rx_empty;   // rx fifo empty

	// compare a count against the fifo capacity
	function automatic logic is_full(input logic [CNT_W-1:0] c);
		is_full = (32'(c) >= 32'(FIFO_DEPTH));
	endfunction

	// empty flags; tx empty shared by the level bits and the underflow event
	assign tx_empty = (TX_CNT_I == '0);
	assign rx_empty = (RX_CNT_I == '0);

	// level bits follow the fifos and slave requests directly, no latching
	always_comb
	begin
		lvl = 32'h0000_0000;
		lvl[imis_pkg::IMIS_B_TXE]   = tx_empty;
		lvl[imis_pkg::IMIS_B_TXLOW] = ({3'b000, TX_CNT_I} <= txthr_r);
		lvl[imis_pkg::IMIS_B_TXF]   = is_full(TX_CNT_I);
		lvl[imis_pkg::IMIS_B_RXE]   = rx_empty;
		lvl[imis_pkg::IMIS_B_RXHI]  = ({3'b000, RX_CNT_I} >= rxthr_r);
		lvl[imis_pkg::IMIS_B_RXF]   = is_full(RX_CNT_I);
		lvl[imis_pkg::IMIS_B_SRDRQ] = LVL_I.slv_rd_req;
		lvl[imis_pkg::IMIS_B_SWRRQ] = LVL_I.slv_wr_req;
	end

	// event vector; underflow is tx empty while a slave read runs
	always_comb
	begin
		set_ev = 32'h0000_0000;
		set_ev[imis_pkg::IMIS_B_TXOVR] = EVT_I.tx_write_full;
		set_ev[imis_pkg::IMIS_B_LEN]   = EVT_I.len_reached;
		set_ev[imis_pkg::IMIS_B_SRDUF] = tx_empty & LVL_I.slv_rd_active;
		set_ev[imis_pkg::IMIS_B_MDONE] = EVT_I.mst_done;
		set_ev[imis_pkg::IMIS_B_SDONE] = EVT_I.slv_done;
		set_ev[imis_pkg::IMIS_B_SARB]  = EVT_I.slv_arb_lost;
		set_ev[imis_pkg::IMIS_B_MARB]  = EVT_I.mst_arb_lost;
		set_ev[imis_pkg::IMIS_B_BERR]  = EVT_I.bus_err;
		set_ev[imis_pkg::IMIS_B_NOSTP] = EVT_I.mst_done_nostop;
	end

	// only ones written to the clear offset act; zeros leave bits alone
	assign clr = (WR_I && ADDR_I == imis_pkg::IMIS_OFS_CLEAR) ?
		(WDATA_I & imis_pkg::IMIS_STICKY) : 32'h0000_0000;

	// sticky bits; a set in the clear cycle wins so no event is lost
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			sticky_r <= imis_pkg::IMIS_RST_WORD;
		else if (CE_I)
			sticky_r <= ((sticky_r & ~clr) | set_ev) & imis_pkg::IMIS_STICKY;
	end

	// software-written control registers
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			mask_r  <= imis_pkg::IMIS_RST_WORD;
			txthr_r <= imis_pkg::IMIS_RST_THR;
			rxthr_r <= imis_pkg::IMIS_RST_THR;
		end
		else if (CE_I && WR_I)
		begin
			if (ADDR_I == imis_pkg::IMIS_OFS_MASK)
				mask_r <= WDATA_I & imis_pkg::IMIS_IMPL_MASK;
			else if (ADDR_I == imis_pkg::IMIS_OFS_TXTHR)
				txthr_r <= WDATA_I[7:0];
			else if (ADDR_I == imis_pkg::IMIS_OFS_RXTHR)
				rxthr_r <= WDATA_I[7:0];
		end
	end

	// raw word: levels and pending events, reserved bits forced low
	assign raw = (lvl | sticky_r) & imis_pkg::IMIS_IMPL_MASK;

	// masked status registered so the output comes from a flop
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			MASKED_O <= imis_pkg::IMIS_RST_WORD;
		else if (CE_I)
			MASKED_O <= raw & mask_r;
	end

	// clock stretch follows the raw nostop bit, independent of the mask
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			SCL_HOLD_O <= 1'b0;
		else if (CE_I)
			SCL_HOLD_O <= raw[imis_pkg::IMIS_B_NOSTP];
	end

	// read port; unmapped addresses return zero
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			RDATA_O <= imis_pkg::IMIS_RST_WORD;
		else if (CE_I)
		begin
			if (!RD_I)
				RDATA_O <= 32'h0000_0000;
			else if (ADDR_I == imis_pkg::IMIS_OFS_MASKED)
				RDATA_O <= raw & mask_r;
			else if (ADDR_I == imis_pkg::IMIS_OFS_RAW)
				RDATA_O <= raw;
			else if (ADDR_I == imis_pkg::IMIS_OFS_MASK)
				RDATA_O <= mask_r;
			else if (ADDR_I == imis_pkg::IMIS_OFS_TXTHR)
				RDATA_O <= {24'h00_0000, txthr_r};
			else if (ADDR_I == imis_pkg::IMIS_OFS_RXTHR)
				RDATA_O <= {24'h00_0000, rxthr_r};
			else
				RDATA_O <= 32'h0000_0000;
		end
	end

	// tx empty shows in masked word one cycle later when enabled
	a_tx_empty_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && tx_empty && mask_r[0] |=> MASKED_O[0])
		else $error("tx empty not reported");
	// threshold compare on tx level
	a_tx_low_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mask_r[1] && ({3'b000, TX_CNT_I} > txthr_r) |=> !MASKED_O[1])
		else $error("tx low reported above threshold");
	// overrun stays until cleared
	a_ovr_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.tx_write_full |=> sticky_r[3])
		else $error("overrun not latched");
	// rx high compare
	a_rx_high_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mask_r[5] && ({3'b000, RX_CNT_I} >= rxthr_r) |=> MASKED_O[5])
		else $error("rx high missed");
	// clear of one bit without event drops it
	a_clear_one: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && clr[19] && !EVT_I.mst_done |=> !sticky_r[19])
		else $error("master done not cleared");
	// write of zero keeps pending bit
	a_clear_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && sticky_r[24] && !clr[24] |=> sticky_r[24])
		else $error("arbitration bit lost");
	// set wins over clear in same cycle
	a_set_wins: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.bus_err && clr[25] |=> sticky_r[25])
		else $error("bus error lost on clear");
	// clock held while nostop pending
	a_scl_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && sticky_r[28] |=> SCL_HOLD_O)
		else $error("clock not held");
	// reserved bits never read one
	a_reserved_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(MASKED_O & ~imis_pkg::IMIS_IMPL_MASK) == 32'h0000_0000)
		else $error("reserved bit set");

	// a tx entry clears the empty bit
	a_tx_nonempty_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && !tx_empty |=> !MASKED_O[0])
		else $error("tx empty reported with data");
	// tx count at or below threshold reports low level
	a_tx_low_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mask_r[1] && ({3'b000, TX_CNT_I} <= txthr_r) |=> MASKED_O[1])
		else $error("tx low missed");
	// tx fifo at capacity
	a_tx_full_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mask_r[2] && (32'(TX_CNT_I) >= 32'(FIFO_DEPTH)) |=> MASKED_O[2])
		else $error("tx full missed");
	// one free tx entry drops the full bit
	a_tx_full_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && (32'(TX_CNT_I) < 32'(FIFO_DEPTH)) |=> !MASKED_O[2])
		else $error("tx full with free entry");
	// rx empty follows the count
	a_rx_empty_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mask_r[4] && rx_empty |=> MASKED_O[4])
		else $error("rx empty not reported");
	// any rx entry clears the empty bit
	a_rx_nonempty_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && !rx_empty |=> !MASKED_O[4])
		else $error("rx empty reported with data");
	// rx count below threshold keeps the high level off
	a_rx_high_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && ({3'b000, RX_CNT_I} < rxthr_r) |=> !MASKED_O[5])
		else $error("rx high below threshold");
	// rx fifo at capacity
	a_rx_full_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mask_r[6] && (32'(RX_CNT_I) >= 32'(FIFO_DEPTH)) |=> MASKED_O[6])
		else $error("rx full missed");
	// fewer rx entries than capacity drops the full bit
	a_rx_full_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && (32'(RX_CNT_I) < 32'(FIFO_DEPTH)) |=> !MASKED_O[6])
		else $error("rx full below capacity");
	// remote read request is a level, not latched
	a_rd_req_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mask_r[16] |=> MASKED_O[16] == $past(LVL_I.slv_rd_req))
		else $error("read request bit wrong");
	// remote write request is a level, not latched
	a_wr_req_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mask_r[18] |=> MASKED_O[18] == $past(LVL_I.slv_wr_req))
		else $error("write request bit wrong");

	// length reached is latched
	a_len_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.len_reached |=> sticky_r[15])
		else $error("length event not latched");
	// tx empty during a slave read is latched
	a_rd_empty_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && tx_empty && LVL_I.slv_rd_active |=> sticky_r[17])
		else $error("read underflow not latched");
	// master done is latched
	a_mdone_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.mst_done |=> sticky_r[19])
		else $error("master done not latched");
	// slave done is latched
	a_sdone_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.slv_done |=> sticky_r[20])
		else $error("slave done not latched");
	// slave arbitration loss is latched
	a_sarb_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.slv_arb_lost |=> sticky_r[23])
		else $error("slave arbitration loss not latched");
	// master arbitration loss is latched
	a_marb_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.mst_arb_lost |=> sticky_r[24])
		else $error("master arbitration loss not latched");
	// bus error is latched
	a_berr_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.bus_err |=> sticky_r[25])
		else $error("bus error not latched");
	// master done without stop is latched
	a_nostop_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && EVT_I.mst_done_nostop |=> sticky_r[28])
		else $error("nostop done not latched");

	// overrun drops on a written one
	a_ovr_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && clr[3] && !EVT_I.tx_write_full |=> !sticky_r[3])
		else $error("overrun not cleared");
	// length bit drops on a written one
	a_len_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && clr[15] && !EVT_I.len_reached |=> !sticky_r[15])
		else $error("length bit not cleared");
	// slave done drops once acknowledged
	a_sdone_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && clr[20] && !EVT_I.slv_done |=> !sticky_r[20])
		else $error("slave done not cleared");
	// nostop bit drops once acknowledged
	a_nostop_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && clr[28] && !EVT_I.mst_done_nostop |=> !sticky_r[28])
		else $error("nostop bit not cleared");
	// clock released once nothing holds it
	a_scl_release: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && !sticky_r[28] |=> !SCL_HOLD_O)
		else $error("clock held without cause");

	// output register is raw and mask of the cycle before
	a_mask_apply: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I |=> MASKED_O == ($past(raw) & $past(mask_r)))
		else $error("masked word wrong");
	// masked read returns the word seen at the strobe
	a_read_masked: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && RD_I && (ADDR_I == imis_pkg::IMIS_OFS_MASKED) |=>
		RDATA_O == ($past(raw) & $past(mask_r)))
		else $error("masked read wrong");
	// read data stand only in the cycle after a strobe
	a_read_idle: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && !RD_I |=> RDATA_O == 32'h0000_0000)
		else $error("read data without strobe");
	// a low enable freezes the sticky, masked output and read data registers
	a_freeze_state: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		!CE_I |=> $stable(sticky_r) && $stable(MASKED_O) && $stable(RDATA_O))
		else $error("state moved while frozen");
endmodule
`default_nettype wire

// >>> imis_far_model.sv
// imis_far_model: bus-side controller stand-in driving events and levels
// assumes tb asks for pulses on FIRE_I and levels on HOLD_I, one clock
`timescale 1ns/100ps
`default_nettype none
module imis_far_model (
	input  wire logic                CLK_I,  // system clock
	input  wire logic [7:0]          FIRE_I, // event request from tb
	input  wire logic [2:0]          HOLD_I, // level request from tb
	output var imis_pkg::imis_evt_t  EVT_O,  // one-cycle event pulses
	output var imis_pkg::imis_lvl_t  LVL_O   // level conditions
);
	// launch after an edge so the block sees a whole cycle of each pulse
	always @(posedge CLK_I)
	begin
		EVT_O <= FIRE_I; // bus events as seen by the engine
		LVL_O <= HOLD_I; // pending remote requests
	end
endmodule
`default_nettype wire

// >>> tb.sv
// tb: self-checking bench for the masked status block
// assumes imis_pkg, imis_top and imis_far_model compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_i = 0, nrst_i = 0, wr = 0, rd = 0;
	logic [7:0] addr = 0, fire = 0;
	logic [31:0] wdata = 0, rdata, masked;
	logic [4:0] tx_cnt = 0, rx_cnt = 0;
	logic [2:0] hold = 0;
	logic scl_hold;
	logic ce = 1'b1;
	imis_pkg::imis_evt_t evt;
	imis_pkg::imis_lvl_t lvl;
	int num_errors = 0, samples_checked = 0;
	int pos [8] = '{28, 25, 24, 23, 20, 19, 15, 3}; // event bit per fire bit
	int cnt [4] = '{0, 3, 4, 16};                    // boundary counts, thr 3
	always #10 clk_i = ~clk_i;
	imis_top dut_u (.CLK_I(clk_i), .NRST_I(nrst_i), .CE_I(ce), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TX_CNT_I(tx_cnt),
		.RX_CNT_I(rx_cnt), .EVT_I(evt), .LVL_I(lvl), .MASKED_O(masked),
		.SCL_HOLD_O(scl_hold));
	imis_far_model far_u (.CLK_I(clk_i), .FIRE_I(fire), .HOLD_I(hold),
		.EVT_O(evt), .LVL_O(lvl));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// let n edges pass, then look at settled outputs
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		@(negedge clk_i);
		chk(rdata, exp);
	endtask
	// fifo level bits for thresholds of 3 and depth 16
	task automatic t_levels;
		logic [31:0] e;
		wr_reg(imis_pkg::IMIS_OFS_MASK, 32'hFFFF_FFFF);
		wr_reg(imis_pkg::IMIS_OFS_TXTHR, 32'h0000_0003);
		wr_reg(imis_pkg::IMIS_OFS_RXTHR, 32'h0000_0003);
		for (int i = 0; i < 4; i++)
		begin
			tx_cnt <= 5'(cnt[i]);
			rx_cnt <= 5'(cnt[3 - i]);
			e = '0;
			e[0] = cnt[i] == 0;
			e[1] = cnt[i] <= 3;
			e[2] = cnt[i] >= 16;
			e[4] = cnt[3 - i] == 0;
			e[5] = cnt[3 - i] >= 3;
			e[6] = cnt[3 - i] >= 16;
			settle(3);
			chk(masked, e);
			rd_reg(imis_pkg::IMIS_OFS_MASKED, e);
		end
	endtask
	// each event sets its bit until a one is written to clear it
	task automatic t_events;
		tx_cnt <= 5'd5;
		rx_cnt <= 5'd1;
		for (int i = 0; i < 8; i++)
		begin
			fire <= 8'(1 << i);
			@(posedge clk_i);
			fire <= '0;
			settle(4);
			chk(masked, 32'(1) << pos[i]);
			chk({31'h0, scl_hold}, {31'h0, i == 0});
			wr_reg(imis_pkg::IMIS_OFS_CLEAR, 32'h0000_0000);
			settle(1);
			chk(masked, 32'(1) << pos[i]);
			wr_reg(imis_pkg::IMIS_OFS_CLEAR, 32'(1) << pos[i]);
			settle(1);
			chk(masked | {31'h0, scl_hold}, 32'h0000_0000);
		end
	endtask
	// remote requests and tx empty during a slave read
	task automatic t_slave;
		hold <= 3'b101;
		settle(3);
		chk(masked, 32'h0005_0000);
		hold <= 3'b010;
		tx_cnt <= 5'd0;
		settle(3);
		chk(masked, 32'h0002_0003);
		hold <= 3'b000;
		tx_cnt <= 5'd5;
		settle(3);
		chk(masked, 32'h0002_0000);
		wr_reg(imis_pkg::IMIS_OFS_CLEAR, 32'h0002_0000);
		settle(1);
		chk(masked, 32'h0000_0000);
	endtask
	// mask hides a raw bit, clock hold ignores the mask
	task automatic t_mask;
		wr_reg(imis_pkg::IMIS_OFS_MASK, 32'h0008_0000);
		fire <= 8'h21;
		@(posedge clk_i);
		fire <= '0;
		settle(4);
		chk(masked, 32'h0008_0000);
		chk({31'h0, scl_hold}, 32'h0000_0001);
		rd_reg(imis_pkg::IMIS_OFS_RAW, 32'h1008_0000);
		rd_reg(8'h00, 32'h0000_0000);
		wr_reg(imis_pkg::IMIS_OFS_CLEAR, 32'h1008_0000);
		rd_reg(imis_pkg::IMIS_OFS_RAW, 32'h0000_0000);
	endtask
	// low enable: event and write are lost, level change shows once it returns
	task automatic t_freeze;
		wr_reg(imis_pkg::IMIS_OFS_MASK, 32'hFFFF_FFFF);
		settle(1);
		ce <= 1'b0;
		tx_cnt <= 5'd0;
		fire <= 8'h04;
		@(posedge clk_i);
		fire <= '0;
		wr_reg(imis_pkg::IMIS_OFS_TXTHR, 32'h0000_0007);
		settle(2);
		chk(masked, 32'h0000_0000);
		ce <= 1'b1;
		settle(2);
		chk(masked, 32'h0000_0003);
		rd_reg(imis_pkg::IMIS_OFS_TXTHR, 32'h0000_0003);
		tx_cnt <= 5'd5;
	endtask
	// reset in mid-run drops pending events and the mask
	task automatic t_reset;
		fire <= 8'h02;
		@(posedge clk_i);
		fire <= '0;
		settle(3);
		chk(masked, 32'h0200_0000);
		nrst_i <= 1'b0;
		settle(1);
		chk(masked | {31'h0, scl_hold}, 32'h0000_0000);
		nrst_i <= 1'b1;
		settle(2);
		chk(masked, 32'h0000_0000);
		rd_reg(imis_pkg::IMIS_OFS_MASK, 32'h0000_0000);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(negedge clk_i);
		chk(masked, 32'h0000_0000);
		rd_reg(imis_pkg::IMIS_OFS_MASKED, 32'h0000_0000);
		t_levels();
		t_events();
		t_slave();
		t_mask();
		t_freeze();
		t_reset();
		final_report();
	end
endmodule
`default_nettype wire
